/* File: scr_pkg.sv */
// How it works
// - Core control only via its own instructions
// - Bits 2:0 pick watchdog prescale 1:1..1:128
// - Bits 5:3 pick timer prescale 1:2..1:256
// - Disable instr sets bit 6; enable/return clear
// - Direction bit 1 input, 0 output; reset ones
// - Serial rate codes: master divides, slave select
// - Serial bits 4/5 make clock/data open-drain
// - Serial function on only while bit 6 set
// - Clock edge bit picks shift-out/in edges
// - Mode bits 1:0 pick operation mode, default 11
// - Remote wake bit set/cleared by host feature
// - Port7 upper pull-ups on at 0, USB only
// - Mode bits 7:6 pick slow-clock frequency
// - Port9 pins 2-4 wake only when bit 0
// - Port9 pins 2,3 pull-up on when bit 0
// - Port5/6 pull-ups on when bits 0/1 clear
// - Resume bit set in slow mode, cleared by suspend falling edge
// - Run bit cleared sleeps; wake falling edge sets it
// - Watchdog runs only while bit 5 set
// - Port-change wake on when bit 6 clear
// - Bit 7 clear selects slow clock, halts USB
// - Sources vector only if masked in and global on
// - Host-resume interrupt only in slow-clock mode
// - Status flags record even when masked
package scr_pkg;
	localparam logic [3:0] SCR_ADDR_P5DIR = 4'h5;
	localparam logic [3:0] SCR_ADDR_P6DIR = 4'h6;
	localparam logic [3:0] SCR_ADDR_P7DIR = 4'h7;
	localparam logic [3:0] SCR_ADDR_SPCFG = 4'h8;
	localparam logic [3:0] SCR_ADDR_P9DIR = 4'h9;
	localparam logic [3:0] SCR_ADDR_MODE = 4'ha;
	localparam logic [3:0] SCR_ADDR_WAKE = 4'hb;
	localparam logic [3:0] SCR_ADDR_LED = 4'hc;
	localparam logic [3:0] SCR_ADDR_PULL = 4'hd;
	localparam logic [3:0] SCR_ADDR_SFC = 4'he;
	localparam logic [3:0] SCR_ADDR_IMASK = 4'hf;
	localparam logic [7:0] SCR_RST_CORE = 8'h3f;
	localparam logic [7:0] SCR_RST_DIR = 8'hff;
	localparam logic [7:0] SCR_RST_SPCFG = 8'h00;
	localparam logic [7:0] SCR_RST_MODE = 8'he3;
	localparam logic [7:0] SCR_RST_WAKE = 8'h7f;
	localparam logic [7:0] SCR_RST_LED = 8'h00;
	localparam logic [7:0] SCR_RST_PULL = 8'hef;
	localparam logic [7:0] SCR_RST_SFC = 8'hd7;
	localparam logic [7:0] SCR_RST_IMASK = 8'h00;
	localparam int SCR_CORE_GIDIS = 6;
	localparam int SCR_SP_CLK_OD = 4;
	localparam int SCR_SP_DAT_OD = 5;
	localparam int SCR_SP_ON = 6;
	localparam int SCR_SP_CES = 7;
	localparam int SCR_MODE_RWAKE = 4;
	localparam int SCR_MODE_P7PU = 5;
	localparam int SCR_SFC_RESUME = 3;
	localparam int SCR_SFC_RUN = 4;
	localparam int SCR_SFC_WDT = 5;
	localparam int SCR_SFC_WUE = 6;
	localparam int SCR_SFC_FAST = 7;
	localparam int SCR_INT_HRES = 7;
	localparam int SCR_WDT_BASE_MS = 8;
	typedef enum logic [1:0] {SCR_DETECT, SCR_USB, SCR_PS2, SCR_USB_TEST} scr_mode_t;
endpackage

/* File: scr_regs.sv */
`timescale 1ns/1ns
module scr_regs
	import scr_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// Core instruction port
	input wire logic i_core_ctrl_write_instr,
	input wire logic i_core_ctrl_read_instr,
	input wire logic i_ctrl_write_instr,
	input wire logic i_ctrl_read_instr,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	input wire logic i_int_disable_instr,
	input wire logic i_int_enable_instr,
	input wire logic i_return_from_int_instr,
	// USB engine events
	input wire logic i_set_feature_rwake,
	input wire logic i_clear_feature_rwake,
	input wire logic i_usb_set_wue,
	input wire logic i_suspend,
	input wire logic i_wakeup,
	// Interrupt flags from sources
	input wire logic [7:0] i_int_flags,
	// Decoded controls
	output logic [2:0] o_watchdog_prescale_sel,
	output logic [2:0] o_timer_prescale_sel,
	output logic [7:0] o_wdt_divide,
	output logic [8:0] o_timer_divide,
	output logic o_int_disabled,
	output logic o_p76_p77_led,
	output logic [7:0] o_p5_dir,
	output logic [7:0] o_p6_dir,
	output logic [7:0] o_p7_dir,
	output logic [7:0] o_p9_dir,
	output logic o_sp_master,
	output logic [6:0] o_sp_divide,
	output logic o_sp_slave_sel_en,
	output logic o_clock_out_opendrain,
	output logic o_data_out_opendrain,
	output logic o_serial_periph_on,
	output logic o_clock_edge_choice,
	output logic [1:0] o_op_mode,
	output logic o_remote_wake,
	output logic o_p7_upper_pullup_en,
	output logic [1:0] o_slow_freq_sel,
	output logic [2:0] o_p9_wake_en,
	output logic [1:0] o_p9_led_sink,
	output logic [1:0] o_p9_pullup_en,
	output logic o_port5_pullup_en,
	output logic o_port6_pullup_en,
	output logic o_device_resume,
	output logic o_sys_clock_run,
	output logic o_watchdog_on,
	output logic o_port_change_wake_en,
	output logic o_slow_clock,
	output logic o_usb_halt,
	output logic o_int_request
);
	logic [7:0] core_ctrl_reg;
	logic [7:0] p5_dir_reg, p6_dir_reg, p7_dir_reg, p9_dir_reg;
	logic [7:0] spcfg_reg, mode_reg, wake_reg, led_reg, pull_reg, sfc_reg, imask_reg;
	logic susp_s1_reg, susp_s2_reg, susp_d_reg;
	logic wake_s1_reg, wake_s2_reg, wake_d_reg;
	logic [7:0] int_pend;
	logic wr_sfc;

	function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] t);
		return i_ctrl_write_instr && (a == t);
	endfunction

	// Pin synchronisers
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			susp_s1_reg <= 1'b0;
			susp_s2_reg <= 1'b0;
			susp_d_reg <= 1'b0;
			wake_s1_reg <= 1'b1;
			wake_s2_reg <= 1'b1;
			wake_d_reg <= 1'b1;
		end else begin
			susp_s1_reg <= i_suspend;
			susp_s2_reg <= susp_s1_reg;
			susp_d_reg <= susp_s2_reg;
			wake_s1_reg <= i_wakeup;
			wake_s2_reg <= wake_s1_reg;
			wake_d_reg <= wake_s2_reg;
		end
	end

	// Core control register
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			core_ctrl_reg <= SCR_RST_CORE;
		end else begin
			if (i_core_ctrl_write_instr) begin
				core_ctrl_reg[7] <= i_wdata[7];
				core_ctrl_reg[5:0] <= i_wdata[5:0];
			end
			if (i_int_disable_instr) begin
				core_ctrl_reg[SCR_CORE_GIDIS] <= 1'b1;
			end else if (i_int_enable_instr || i_return_from_int_instr) begin
				core_ctrl_reg[SCR_CORE_GIDIS] <= 1'b0;
			end
		end
	end

	// Plain control registers
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			p5_dir_reg <= SCR_RST_DIR;
			p6_dir_reg <= SCR_RST_DIR;
			p7_dir_reg <= SCR_RST_DIR;
			p9_dir_reg <= SCR_RST_DIR;
			spcfg_reg <= SCR_RST_SPCFG;
			wake_reg <= SCR_RST_WAKE;
			led_reg <= SCR_RST_LED;
			pull_reg <= SCR_RST_PULL;
			imask_reg <= SCR_RST_IMASK;
		end else begin
			if (wr_hit(i_addr, SCR_ADDR_P5DIR)) p5_dir_reg <= i_wdata;
			if (wr_hit(i_addr, SCR_ADDR_P6DIR)) p6_dir_reg <= i_wdata;
			if (wr_hit(i_addr, SCR_ADDR_P7DIR)) p7_dir_reg <= i_wdata;
			if (wr_hit(i_addr, SCR_ADDR_P9DIR)) p9_dir_reg <= i_wdata;
			if (wr_hit(i_addr, SCR_ADDR_SPCFG)) spcfg_reg <= i_wdata & 8'hf7;
			if (wr_hit(i_addr, SCR_ADDR_WAKE)) wake_reg <= i_wdata;
			if (wr_hit(i_addr, SCR_ADDR_LED)) led_reg <= i_wdata;
			if (wr_hit(i_addr, SCR_ADDR_PULL)) pull_reg <= i_wdata;
			if (wr_hit(i_addr, SCR_ADDR_IMASK)) imask_reg <= i_wdata;
		end
	end

	// Operation mode register; host feature requests win over writes
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mode_reg <= SCR_RST_MODE;
		end else begin
			if (wr_hit(i_addr, SCR_ADDR_MODE)) mode_reg <= i_wdata & 8'hf3;
			if (i_set_feature_rwake) begin
				mode_reg[SCR_MODE_RWAKE] <= 1'b1;
			end else if (i_clear_feature_rwake) begin
				mode_reg[SCR_MODE_RWAKE] <= 1'b0;
			end
		end
	end

	// Special function register
	assign wr_sfc = wr_hit(i_addr, SCR_ADDR_SFC);
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sfc_reg <= SCR_RST_SFC;
		end else begin
			if (wr_sfc) begin
				sfc_reg[7:4] <= i_wdata[7:4];
				sfc_reg[1:0] <= i_wdata[1:0];
				sfc_reg[SCR_SFC_RESUME] <= i_wdata[SCR_SFC_RESUME]
					&& !sfc_reg[SCR_SFC_FAST];
			end
			if (susp_d_reg && !susp_s2_reg) begin
				sfc_reg[SCR_SFC_RESUME] <= 1'b0;
			end
			if (i_usb_set_wue) begin
				sfc_reg[SCR_SFC_WUE] <= 1'b1;
			end
			if (wake_d_reg && !wake_s2_reg) begin
				sfc_reg[SCR_SFC_RUN] <= 1'b1;
			end
		end
	end

	// Interrupt gating; flags are kept by sources regardless of mask
	always_comb begin
		int_pend = i_int_flags & imask_reg;
		int_pend[6] = 1'b0;
		if (sfc_reg[SCR_SFC_FAST]) int_pend[SCR_INT_HRES] = 1'b0;
	end

	// Read data and decoded outputs
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= 8'h00;
		end else if (i_core_ctrl_read_instr) begin
			o_rdata <= core_ctrl_reg;
		end else if (i_ctrl_read_instr) begin
			unique case (i_addr)
				SCR_ADDR_P5DIR: o_rdata <= p5_dir_reg;
				SCR_ADDR_P6DIR: o_rdata <= p6_dir_reg;
				SCR_ADDR_P7DIR: o_rdata <= p7_dir_reg;
				SCR_ADDR_SPCFG: o_rdata <= spcfg_reg;
				SCR_ADDR_P9DIR: o_rdata <= p9_dir_reg;
				SCR_ADDR_MODE: o_rdata <= mode_reg;
				SCR_ADDR_WAKE: o_rdata <= wake_reg;
				SCR_ADDR_LED: o_rdata <= led_reg;
				SCR_ADDR_PULL: o_rdata <= pull_reg;
				SCR_ADDR_SFC: o_rdata <= sfc_reg;
				SCR_ADDR_IMASK: o_rdata <= imask_reg;
				default: o_rdata <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_watchdog_prescale_sel <= SCR_RST_CORE[2:0];
			o_timer_prescale_sel <= SCR_RST_CORE[5:3];
			o_wdt_divide <= 8'h80;
			o_timer_divide <= 9'h100;
			o_int_disabled <= 1'b0;
			o_p76_p77_led <= 1'b0;
			o_p5_dir <= SCR_RST_DIR;
			o_p6_dir <= SCR_RST_DIR;
			o_p7_dir <= SCR_RST_DIR;
			o_p9_dir <= SCR_RST_DIR;
			o_sp_master <= 1'b1;
			o_sp_divide <= 7'h02;
			o_sp_slave_sel_en <= 1'b0;
			o_clock_out_opendrain <= 1'b0;
			o_data_out_opendrain <= 1'b0;
			o_serial_periph_on <= 1'b0;
			o_clock_edge_choice <= 1'b0;
			o_op_mode <= SCR_USB_TEST;
			o_remote_wake <= 1'b0;
			o_p7_upper_pullup_en <= 1'b0;
			o_slow_freq_sel <= 2'h3;
			o_p9_wake_en <= 3'h0;
			o_p9_led_sink <= 2'h0;
			o_p9_pullup_en <= 2'h0;
			o_port5_pullup_en <= 1'b0;
			o_port6_pullup_en <= 1'b0;
			o_device_resume <= 1'b0;
			o_sys_clock_run <= 1'b1;
			o_watchdog_on <= 1'b0;
			o_port_change_wake_en <= 1'b0;
			o_slow_clock <= 1'b0;
			o_usb_halt <= 1'b0;
			o_int_request <= 1'b0;
		end else begin
			o_watchdog_prescale_sel <= core_ctrl_reg[2:0];
			o_timer_prescale_sel <= core_ctrl_reg[5:3];
			o_wdt_divide <= 8'h01 << core_ctrl_reg[2:0];
			o_timer_divide <= 9'h002 << core_ctrl_reg[5:3];
			o_int_disabled <= core_ctrl_reg[SCR_CORE_GIDIS];
			o_p76_p77_led <= core_ctrl_reg[7];
			o_p5_dir <= p5_dir_reg;
			o_p6_dir <= p6_dir_reg;
			o_p7_dir <= p7_dir_reg;
			o_p9_dir <= p9_dir_reg;
			o_sp_master <= spcfg_reg[2:0] < 3'h6;
			o_sp_divide <= (spcfg_reg[2:0] < 3'h6) ? 7'h02 << spcfg_reg[2:0] : 7'h00;
			o_sp_slave_sel_en <= spcfg_reg[2:0] == 3'h6;
			o_clock_out_opendrain <= spcfg_reg[SCR_SP_CLK_OD];
			o_data_out_opendrain <= spcfg_reg[SCR_SP_DAT_OD];
			o_serial_periph_on <= spcfg_reg[SCR_SP_ON];
			o_clock_edge_choice <= spcfg_reg[SCR_SP_CES];
			o_op_mode <= mode_reg[1:0];
			o_remote_wake <= mode_reg[SCR_MODE_RWAKE];
			o_p7_upper_pullup_en <= !mode_reg[SCR_MODE_P7PU]
				&& (mode_reg[1:0] == SCR_USB);
			o_slow_freq_sel <= mode_reg[7:6];
			o_p9_wake_en <= ~wake_reg[4:2];
			o_p9_led_sink <= led_reg[3:2];
			o_p9_pullup_en <= ~pull_reg[3:2];
			o_port5_pullup_en <= !sfc_reg[0];
			o_port6_pullup_en <= !sfc_reg[1];
			o_device_resume <= sfc_reg[SCR_SFC_RESUME];
			o_sys_clock_run <= sfc_reg[SCR_SFC_RUN];
			o_watchdog_on <= sfc_reg[SCR_SFC_WDT];
			o_port_change_wake_en <= !sfc_reg[SCR_SFC_WUE];
			o_slow_clock <= !sfc_reg[SCR_SFC_FAST];
			o_usb_halt <= !sfc_reg[SCR_SFC_FAST];
			o_int_request <= (|int_pend) && !core_ctrl_reg[SCR_CORE_GIDIS];
		end
	end
endmodule

/* File: scr_regs_chk.sv */
`timescale 1ns/1ns
module scr_regs_chk (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// Watched ports
	input wire logic i_core_ctrl_write_instr,
	input wire logic i_ctrl_write_instr,
	input wire logic i_ctrl_read_instr,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] o_rdata,
	input wire logic i_int_disable_instr,
	input wire logic i_int_enable_instr,
	input wire logic i_return_from_int_instr,
	input wire logic [2:0] o_watchdog_prescale_sel,
	input wire logic [2:0] o_timer_prescale_sel,
	input wire logic [7:0] o_wdt_divide,
	input wire logic [8:0] o_timer_divide,
	input wire logic o_int_disabled,
	input wire logic [7:0] o_p5_dir,
	input wire logic o_sp_master,
	input wire logic [6:0] o_sp_divide,
	input wire logic [1:0] o_op_mode,
	input wire logic o_p7_upper_pullup_en,
	input wire logic o_slow_clock,
	input wire logic o_usb_halt
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	AST_GIDIS_SET: assert property (i_int_disable_instr |-> ##2 o_int_disabled)
		else $error("int disable not set");
	AST_GIDIS_CLR: assert property ((i_int_enable_instr || i_return_from_int_instr) && !i_int_disable_instr |-> ##2 !o_int_disabled)
		else $error("int disable not cleared");
	AST_CORE_WR: assert property (i_core_ctrl_write_instr |-> ##2 {5'h00, o_watchdog_prescale_sel} == ($past(i_wdata, 2) & 8'h07))
		else $error("watchdog select wrong");
	AST_WDT_DIV: assert property (o_wdt_divide == (8'h01 << o_watchdog_prescale_sel))
		else $error("watchdog divide wrong");
	AST_TMR_DIV: assert property (o_timer_divide == (9'h002 << o_timer_prescale_sel))
		else $error("timer divide wrong");
	AST_DIR_WR: assert property (i_ctrl_write_instr && i_addr == 4'h5 |-> ##2 o_p5_dir == $past(i_wdata, 2))
		else $error("direction not written");
	AST_SP_SLAVE: assert property (!o_sp_master |-> o_sp_divide == 7'h00)
		else $error("slave has a divide");
	AST_P7_PU: assert property (o_p7_upper_pullup_en |-> o_op_mode == 2'h1)
		else $error("pull-up outside usb mode");
	AST_SLOW: assert property (i_ctrl_write_instr && i_addr == 4'he && !i_wdata[7] |-> ##2 o_slow_clock && o_usb_halt)
		else $error("slow clock not taken");
	AST_UNMAPPED: assert property (i_ctrl_read_instr && i_addr < 4'h5 |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	cover property (i_int_disable_instr);
	cover property (!o_sp_master);
	cover property (o_slow_clock);
endmodule
bind scr_regs scr_regs_chk u_scr_regs_chk (.i_clock, .i_rst_b, .i_core_ctrl_write_instr,
	.i_ctrl_write_instr, .i_ctrl_read_instr, .i_addr, .i_wdata, .o_rdata, .i_int_disable_instr,
	.i_int_enable_instr, .i_return_from_int_instr, .o_watchdog_prescale_sel, .o_timer_prescale_sel,
	.o_wdt_divide, .o_timer_divide, .o_int_disabled, .o_p5_dir, .o_sp_master, .o_sp_divide,
	.o_op_mode, .o_p7_upper_pullup_en, .o_slow_clock, .o_usb_halt);

/* File: scr_regs_tb_top.sv */
`timescale 1ns/1ns
module scr_regs_tb_top;
	logic i_clock = 0, i_rst_b = 0, i_core_ctrl_write_instr = 0, i_core_ctrl_read_instr = 0;
	logic i_ctrl_write_instr = 0, i_ctrl_read_instr = 0, i_int_disable_instr = 0;
	logic i_int_enable_instr = 0, i_return_from_int_instr = 0, i_set_feature_rwake = 0;
	logic i_clear_feature_rwake = 0, i_usb_set_wue = 0, i_suspend = 0, i_wakeup = 1;
	logic [7:0] o_p5_dir, o_p6_dir, o_p7_dir, o_p9_dir;
	logic [2:0] o_p9_wake_en;
	logic [1:0] o_p9_led_sink, o_p9_pullup_en;
	logic o_port5_pullup_en, o_port6_pullup_en;
	logic [3:0] i_addr = '0, a4;
	logic [7:0] i_wdata = '0, i_int_flags = '0, o_rdata, o_wdt_divide, rd, v;
	logic [8:0] o_timer_divide;
	logic [6:0] o_sp_divide;
	logic [2:0] o_watchdog_prescale_sel, o_timer_prescale_sel;
	logic [1:0] o_op_mode, o_slow_freq_sel;
	logic o_int_disabled, o_p76_p77_led, o_sp_master, o_sp_slave_sel_en, o_clock_out_opendrain;
	logic o_data_out_opendrain, o_serial_periph_on, o_clock_edge_choice, o_remote_wake;
	logic o_p7_upper_pullup_en, o_device_resume, o_sys_clock_run, o_watchdog_on;
	logic o_port_change_wake_en, o_slow_clock, o_usb_halt, o_int_request;
	int n_fail = 0, checks = 0, cyc = 0;
	int aa[5] = '{5, 6, 7, 9, 15};
	logic [7:0] rst_tab[16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff,
		8'h00, 8'hff, 8'he3, 8'h7f, 8'h00, 8'hef, 8'hd7, 8'h00};
	scr_regs u_scr_regs (.i_clock, .i_rst_b, .i_core_ctrl_write_instr, .i_core_ctrl_read_instr,
		.i_ctrl_write_instr, .i_ctrl_read_instr, .i_addr, .i_wdata, .o_rdata, .i_int_disable_instr,
		.i_int_enable_instr, .i_return_from_int_instr, .i_set_feature_rwake, .i_clear_feature_rwake,
		.i_usb_set_wue, .i_suspend, .i_wakeup, .i_int_flags, .o_watchdog_prescale_sel,
		.o_timer_prescale_sel, .o_wdt_divide, .o_timer_divide, .o_int_disabled, .o_p76_p77_led,
		.o_p5_dir, .o_p6_dir, .o_p7_dir, .o_p9_dir, .o_sp_master, .o_sp_divide,
		.o_sp_slave_sel_en, .o_clock_out_opendrain, .o_data_out_opendrain, .o_serial_periph_on,
		.o_clock_edge_choice, .o_op_mode, .o_remote_wake, .o_p7_upper_pullup_en, .o_slow_freq_sel,
		.o_p9_wake_en, .o_p9_led_sink, .o_p9_pullup_en, .o_port5_pullup_en,
		.o_port6_pullup_en, .o_device_resume, .o_sys_clock_run, .o_watchdog_on,
		.o_port_change_wake_en, .o_slow_clock, .o_usb_halt, .o_int_request);
	always #2 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic acc(logic w, logic c, logic [3:0] a, logic [7:0] d);
		tick(1);
		i_addr = a;
		i_wdata = d;
		{i_core_ctrl_write_instr, i_ctrl_write_instr} = {w & c, w & !c};
		{i_core_ctrl_read_instr, i_ctrl_read_instr} = {!w & c, !w & !c};
		tick(1);
		{i_core_ctrl_write_instr, i_ctrl_write_instr, i_core_ctrl_read_instr, i_ctrl_read_instr} = '0;
		rd = o_rdata;
		tick(1);
	endtask
	task automatic ins(logic [5:0] k);
		tick(1);
		{i_int_disable_instr, i_int_enable_instr, i_return_from_int_instr, i_set_feature_rwake,
			i_clear_feature_rwake, i_usb_set_wue} = k;
		tick(1);
		{i_int_disable_instr, i_int_enable_instr, i_return_from_int_instr, i_set_feature_rwake,
			i_clear_feature_rwake, i_usb_set_wue} = '0;
		tick(2);
	endtask
	function automatic logic [6:0] sp_div(logic [2:0] c);
		return (c < 3'h6) ? (7'h02 << c) : 7'h00;
	endfunction
	initial begin
		v = 8'($urandom(32'hccc1807c));
		repeat (5) @(posedge i_clock);
		#1 i_rst_b = 1;
		for (int a = 0; a < 16; a++) begin
			acc(0, 0, 4'(a), 8'h00);
			chk("rst", rst_tab[a], rd);
		end
		acc(0, 1, 4'h0, 8'h00);
		chk("core_rst", 8'h3f, rd);
		for (int i = 0; i < 20; i++) begin
			a4 = 4'(aa[i % 5]);
			v = (i < 5) ? 8'h00 : 8'($urandom);
			acc(1, 0, a4, v);
			acc(0, 0, a4, 8'h00);
			chk("rw", v, rd);
			if (a4 == 4'h5) chk("p5d", v, o_p5_dir);
			if (a4 == 4'h6) chk("p6d", v, o_p6_dir);
			if (a4 == 4'h7) chk("p7d", v, o_p7_dir);
			if (a4 == 4'h9) chk("p9d", v, o_p9_dir);
		end
		ins(6'h20);
		chk("gdis", 1, o_int_disabled);
		ins(6'h08);
		chk("gdis", 0, o_int_disabled);
		ins(6'h30);
		chk("gdis", 1, o_int_disabled);
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 8'hff : 8'($urandom);
			acc(1, 1, 4'h0, v);
			acc(0, 1, 4'h0, 8'h00);
			chk("core", {v[7], 1'b1, v[5:0]}, rd);
			chk("wdt", 9'h001 << v[2:0], o_wdt_divide);
			chk("tmr", 9'h002 << v[5:3], o_timer_divide);
			chk("psel", v[2:0], o_watchdog_prescale_sel);
			chk("tsel", v[5:3], o_timer_prescale_sel);
			chk("led", v[7], o_p76_p77_led);
		end
		for (int c = 0; c < 8; c++) begin
			v = {c[0], c[1], c[2], c[0], 1'b1, 3'(c)};
			acc(1, 0, 4'h8, v);
			acc(0, 0, 4'h8, 8'h00);
			chk("sp", v & 8'hf7, rd);
			chk("div", sp_div(3'(c)), o_sp_divide);
			chk("mst", c < 6, o_sp_master);
			chk("ssel", c == 6, o_sp_slave_sel_en);
			chk("ckod", v[4], o_clock_out_opendrain);
			chk("dod", v[5], o_data_out_opendrain);
			chk("spon", v[6], o_serial_periph_on);
			chk("ces", v[7], o_clock_edge_choice);
		end
		for (int m = 0; m < 4; m++) begin
			acc(1, 0, 4'ha, {2'(m), 4'h3, 2'(m)});
			chk("om", m, o_op_mode);
			chk("p7pu", m == 1, o_p7_upper_pullup_en);
			chk("sfq", m, o_slow_freq_sel);
		end
		acc(0, 0, 4'ha, 8'h00);
		chk("mrd", 8'hc3, rd);
		ins(6'h04);
		chk("rwk", 1, o_remote_wake);
		ins(6'h02);
		chk("rwk", 0, o_remote_wake);
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'h00 : 8'($urandom);
			acc(1, 0, 4'hb, v);
			acc(1, 0, 4'hc, v);
			acc(1, 0, 4'hd, v);
			acc(1, 0, 4'he, {6'h35, v[1:0]});
			chk("p9wk", 3'(~v[4:2]), o_p9_wake_en);
			chk("p9led", v[3:2], o_p9_led_sink);
			chk("p9pu", 2'(~v[3:2]), o_p9_pullup_en);
			chk("pu5", !v[0], o_port5_pullup_en);
			chk("pu6", !v[1], o_port6_pullup_en);
		end
		acc(1, 0, 4'he, 8'h77);
		chk("slow", 1, o_slow_clock);
		chk("halt", 1, o_usb_halt);
		chk("wdon", 1, o_watchdog_on);
		acc(1, 0, 4'he, 8'h7f);
		chk("res", 1, o_device_resume);
		i_suspend = 1;
		tick(4);
		i_suspend = 0;
		tick(8);
		chk("res", 0, o_device_resume);
		acc(1, 0, 4'he, 8'h87);
		acc(1, 0, 4'he, 8'h8f);
		acc(0, 0, 4'he, 8'h00);
		chk("sfc", 8'h87, rd);
		chk("run", 0, o_sys_clock_run);
		chk("wdon", 0, o_watchdog_on);
		chk("pcw", 1, o_port_change_wake_en);
		ins(6'h01);
		chk("pcw", 0, o_port_change_wake_en);
		i_wakeup = 1;
		tick(4);
		i_wakeup = 0;
		tick(8);
		chk("run", 1, o_sys_clock_run);
		i_wakeup = 1;
		acc(1, 0, 4'hf, 8'h81);
		i_int_flags = 8'h81;
		ins(6'h10);
		chk("irq", 1, o_int_request);
		ins(6'h20);
		chk("irq", 0, o_int_request);
		ins(6'h10);
		acc(1, 0, 4'hf, 8'h80);
		tick(1);
		chk("irq", 0, o_int_request);
		acc(1, 0, 4'he, 8'h37);
		tick(2);
		chk("irq", 1, o_int_request);
		summarize();
	end
endmodule
